// file: design/ifd_pkg.sv
// Constants for the instruction field decoder: field positions, widths.
// Assumes big-endian bit numbering: instruction bit 0 is word bit 31.
// Operation
// RQ1: Float status mask bits 7..14 select nibbles 0..7
// RQ2: Condition mask bits 12..19 enable nibbles 0..7
// RQ3: Long branch offset: 24 bits, append 00, sign-extend
// RQ4: Branch return-save flag writes link register
// RQ5: Supervisor call return-save flag loads link register
// RQ6: Vector address is one, index, five zeros
// RQ7: Start below stop+1: ones start through stop
// RQ8: Start equals stop+1: all ones
// RQ9: Start above stop+1: zeros stop+1..start-1
// RQ10: String byte count from bits 16..20
// RQ11: Primary opcode from bits 0..5
// RQ12: Overflow enable bit 21 gates exception update
// RQ13: Fixed-point record flag sets condition bits 0..3
// RQ14: Float record flag copies summaries to bits 4..7
// RQ15: Four-bit immediate status from bits 16..19
// RQ16: Recognise nine-bit and ten-bit extended opcodes
// RQ17: Float sources from 11:15, 16:20, 21:25
// RQ18: Float target and store source from 6:10
// RQ19: First general operand from bits 11..15
// RQ20: Second general operand from bits 16..20
// RQ21: Extract supervisor four-bit and three-bit fields
// RQ22: Absolute flag bit 30 selects addressing form
// RQ23: Register outputs; reset gives no-operation decode
package ifd_pkg;
    // Word width and implementation address width
    localparam int IFD_W = 32;
    localparam int IFD_AW = 64;
    // Converts documented bit number to word bit index
    localparam int IFD_MSB = 31;
    // Field start positions in documented numbering
    localparam int IFD_OPC_POS = 0;
    localparam int IFD_F610_POS = 6;
    localparam int IFD_F1115_POS = 11;
    localparam int IFD_F1620_POS = 16;
    localparam int IFD_F2125_POS = 21;
    localparam int IFD_F2630_POS = 26;
    localparam int IFD_FMASK_POS = 7;
    localparam int IFD_CMASK_POS = 12;
    localparam int IFD_SF4_POS = 16;
    localparam int IFD_SF3_POS = 27;
    localparam int IFD_VIX_POS = 20;
    localparam int IFD_BOF_POS = 6;
    localparam int IFD_XO_POS = 21;
    localparam int IFD_OE_POS = 21;
    localparam int IFD_XO9_POS = 22;
    localparam int IFD_ABS_POS = 30;
    localparam int IFD_LNK_POS = 31;
    // Field widths
    localparam int IFD_OPC_W = 6;
    localparam int IFD_REG_W = 5;
    localparam int IFD_MASK8_W = 8;
    localparam int IFD_NIB_W = 4;
    localparam int IFD_SF3_W = 3;
    localparam int IFD_VIX_W = 7;
    localparam int IFD_BOF_W = 24;
    localparam int IFD_XO_W = 10;
    localparam int IFD_XO9_W = 9;
    // Primary opcodes of the forms the decoder classifies
    localparam logic [5:0] IFD_OP_BRANCH = 6'h12;
    localparam logic [5:0] IFD_OP_SVC = 6'h11;
    localparam logic [5:0] IFD_OP_EXT = 6'h1f;
    localparam logic [5:0] IFD_OP_FLT_A = 6'h3f;
    localparam logic [5:0] IFD_OP_FLT_B = 6'h3b;
    // Extended opcode of move-to-condition-fields
    localparam logic [9:0] IFD_XO_MTCRF = 10'h090;
    // Extended opcode of move-to-float-status-fields
    localparam logic [9:0] IFD_XO_MTFSF = 10'h2c7;
    // Extended opcode of move-to-float-status-immediate
    localparam logic [9:0] IFD_XO_MTFSFI = 10'h086;
    // Reset value: a no-operation word, all fields but the opcode zero
    localparam logic [31:0] IFD_NOP_WORD = 32'h60000000;
endpackage

// file: design/ifd_rotate_mask.sv
// Rotate mask builder: start and stop indices to a 32-bit mask.
// Assumes indices in documented numbering; combinational only.
`timescale 1ns/10ps
module ifd_rotate_mask (
    input wire logic [4:0] start_idx,
    input wire logic [4:0] stop_idx,
    output logic [31:0] mask
);
    // ----------------------------------------------------------------
    // Per-bit mask generation
    // ----------------------------------------------------------------
    // Compared at six bits so that stop+1 never wraps to zero
    logic [5:0] stop_p1;
    logic [5:0] start_x;
    assign stop_p1 = {1'h0, stop_idx} + 6'h01;
    assign start_x = {1'h0, start_idx};

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_bit
            // Documented bit gi lands on word bit 31-gi
            localparam logic [5:0] P = 6'(gi);
            logic in_run;
            logic in_gap;
            assign in_run = (P >= start_x) && (P <= {1'h0, stop_idx});
            assign in_gap = (P >= stop_p1) && (P < start_x);
            always_comb begin
                if (start_x < stop_p1) begin
                    mask[31 - gi] = in_run; // RQ7
                end else if (start_x == stop_p1) begin
                    mask[31 - gi] = 1'h1; // RQ8
                end else begin
                    mask[31 - gi] = ~in_gap; // RQ9
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    always_comb begin
        if (start_x == stop_p1) begin
            // Deferred so that a bit still settling cannot fire it
            a_mask_full: assert final (mask == 32'hffffffff) // RQ8
                else $error("mask not all ones at wrap");
        end
    end
endmodule

// file: design/ifd_decoder.sv
// Instruction field decoder top: fields, masks, controls, registered.
// Assumes one fetch-stage word per cycle on REF_CLK, qualified by valid.
`timescale 1ns/10ps
module ifd_decoder (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic INSTR_VALID,
    input wire logic [31:0] INSTR_WORD,
    input wire logic [63:0] INSTR_ADDR,
    output logic DEC_VALID,
    output logic [5:0] PRIMARY_OPCODE,
    output logic [4:0] FPR_TARGET,
    output logic [4:0] FPR_STORE_SOURCE,
    output logic [4:0] FPR_SOURCE_A,
    output logic [4:0] FPR_SOURCE_B,
    output logic [4:0] FPR_SOURCE_C,
    output logic [4:0] FIRST_GPR_OPERAND,
    output logic [4:0] SECOND_GPR_OPERAND,
    output logic [4:0] STRING_BYTE_COUNT,
    output logic [3:0] FLOAT_STATUS_IMM,
    output logic [9:0] EXT_OPCODE10,
    output logic [8:0] EXT_OPCODE9,
    output logic [7:0] FLOAT_STATUS_UPDATE_MASK,
    output logic [7:0] CONDITION_UPDATE_MASK,
    output logic [31:0] FLOAT_STATUS_WRITE_EN,
    output logic [31:0] CONDITION_WRITE_EN,
    output logic [63:0] LONG_BRANCH_OFFSET,
    output logic [31:0] ROTATE_MASK,
    output logic LINK_WRITE_EN,
    output logic [63:0] LINK_VALUE,
    output logic SUPERVISOR_ABSOLUTE_FLAG,
    output logic [6:0] SUPERVISOR_VECTOR_INDEX,
    output logic [12:0] SUPERVISOR_VECTOR_ADDR,
    output logic [3:0] SUPERVISOR_FOUR_BIT_FIELD,
    output logic [2:0] SUPERVISOR_THREE_BIT_FIELD,
    output logic OVERFLOW_UPDATE_EN,
    output logic RECORD_FIXED_EN,
    output logic RECORD_FLOAT_EN
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Everything the decoder presents, held in one packed record
    typedef struct packed {
        logic vld;
        logic [5:0] opc;
        logic [4:0] r610;
        logic [4:0] r1115;
        logic [4:0] r1620;
        logic [4:0] r2125;
        logic [3:0] imm4;
        logic [9:0] xo10;
        logic [8:0] xo9;
        logic [7:0] fmask;
        logic [7:0] cmask;
        logic [31:0] fm_en;
        logic [31:0] cm_en;
        logic [63:0] bof;
        logic [31:0] rmask;
        logic lnk_en;
        logic [63:0] lnk_val;
        logic absf;
        logic [6:0] vix;
        logic [12:0] vec;
        logic [3:0] sf4;
        logic [2:0] sf3;
        logic oe_en;
        logic rec_fix;
        logic rec_flt;
    } ifd_state_s;

    ifd_state_s st_r; // Registered decode
    ifd_state_s st_nxt; // Next decode

    // ----------------------------------------------------------------
    // Field access helper
    // ----------------------------------------------------------------
    // Documented bit n of the word is word bit 31-n
    function automatic logic dbit(input logic [31:0] w, input int n);
        dbit = w[ifd_pkg::IFD_MSB - n];
    endfunction

    // Pull a field given its documented start and width (<=10 bits)
    function automatic logic [9:0] dfield(input logic [31:0] w,
                                          input int pos, input int wid);
        logic [9:0] f;
        f = 10'h000;
        for (int i = 0; i < wid; i++) begin
            f[wid - 1 - i] = w[ifd_pkg::IFD_MSB - pos - i];
        end
        dfield = f;
    endfunction

    // ----------------------------------------------------------------
    // Mask builder
    // ----------------------------------------------------------------
    logic [4:0] mstart; // Mask start index
    logic [4:0] mstop; // Mask stop index
    logic [31:0] rmask; // Built rotate mask
    assign mstart = 5'(dfield(INSTR_WORD, ifd_pkg::IFD_F2125_POS,
                              ifd_pkg::IFD_REG_W));
    assign mstop = 5'(dfield(INSTR_WORD, ifd_pkg::IFD_F2630_POS,
                             ifd_pkg::IFD_REG_W));

    ifd_rotate_mask u_rmask (
        .start_idx(mstart),
        .stop_idx(mstop),
        .mask(rmask)
    );

    // ----------------------------------------------------------------
    // Nibble enable expansion
    // ----------------------------------------------------------------
    // Mask bit k (k=0 leftmost) covers register nibble k, bits 4k..4k+3
    logic [7:0] fmask_f; // Float status update mask
    logic [7:0] cmask_f; // Condition update mask
    logic [31:0] fmask_x; // Per-bit float status enables
    logic [31:0] cmask_x; // Per-bit condition enables
    assign fmask_f = 8'(dfield(INSTR_WORD, ifd_pkg::IFD_FMASK_POS,
                               ifd_pkg::IFD_MASK8_W));
    assign cmask_f = 8'(dfield(INSTR_WORD, ifd_pkg::IFD_CMASK_POS,
                               ifd_pkg::IFD_MASK8_W));

    genvar gn;
    generate
        for (gn = 0; gn < 8; gn++) begin : g_nib
            // Register nibble gn sits at word bits 31-4gn down to 28-4gn
            assign fmask_x[31 - 4*gn -: 4] = {4{fmask_f[7 - gn]}}; // RQ1
            assign cmask_x[31 - 4*gn -: 4] = {4{cmask_f[7 - gn]}}; // RQ2
        end
    endgenerate

    // ----------------------------------------------------------------
    // Combinational decode
    // ----------------------------------------------------------------
    // Classifies the word and fills every field of the next state
    always_comb begin
        logic [5:0] opc;
        logic [9:0] xo10;
        logic [8:0] xo9;
        logic [23:0] ofs24;
        logic is_br;
        logic is_svc;
        logic is_ext;
        logic is_flt;
        logic lnk;
        opc = 6'(dfield(INSTR_WORD, ifd_pkg::IFD_OPC_POS,
                        ifd_pkg::IFD_OPC_W)); // RQ11
        xo10 = dfield(INSTR_WORD, ifd_pkg::IFD_XO_POS,
                      ifd_pkg::IFD_XO_W);
        xo9 = 9'(dfield(INSTR_WORD, ifd_pkg::IFD_XO9_POS,
                        ifd_pkg::IFD_XO9_W)); // RQ16
        ofs24 = '0;
        for (int i = 0; i < ifd_pkg::IFD_BOF_W; i++) begin
            ofs24[ifd_pkg::IFD_BOF_W - 1 - i] =
                dbit(INSTR_WORD, ifd_pkg::IFD_BOF_POS + i);
        end
        is_br = (opc == ifd_pkg::IFD_OP_BRANCH);
        is_svc = (opc == ifd_pkg::IFD_OP_SVC);
        is_ext = (opc == ifd_pkg::IFD_OP_EXT);
        is_flt = (opc == ifd_pkg::IFD_OP_FLT_A) ||
                 (opc == ifd_pkg::IFD_OP_FLT_B);
        lnk = dbit(INSTR_WORD, ifd_pkg::IFD_LNK_POS);

        st_nxt = st_r;
        // Idle cycles fall back to the quiet no-operation decode
        if (!INSTR_VALID) begin
            st_nxt = '0;
            st_nxt.opc = ifd_pkg::IFD_NOP_WORD[31:26];
        end else begin
            st_nxt.vld = 1'h1;
            st_nxt.opc = opc;
            // Shared 6:10 slot: float target or store source
            st_nxt.r610 = 5'(dfield(INSTR_WORD, ifd_pkg::IFD_F610_POS,
                                    ifd_pkg::IFD_REG_W)); // RQ18
            st_nxt.r1115 = 5'(dfield(INSTR_WORD, ifd_pkg::IFD_F1115_POS,
                                     ifd_pkg::IFD_REG_W)); // RQ17 RQ19
            st_nxt.r1620 = 5'(dfield(INSTR_WORD, ifd_pkg::IFD_F1620_POS,
                                     ifd_pkg::IFD_REG_W)); // RQ20 RQ10
            st_nxt.r2125 = 5'(dfield(INSTR_WORD, ifd_pkg::IFD_F2125_POS,
                                     ifd_pkg::IFD_REG_W)); // RQ17
            st_nxt.imm4 = 4'(dfield(INSTR_WORD, ifd_pkg::IFD_F1620_POS,
                                    ifd_pkg::IFD_NIB_W)); // RQ15
            st_nxt.xo10 = xo10; // RQ16
            st_nxt.xo9 = xo9;
            st_nxt.fmask = fmask_f;
            st_nxt.cmask = cmask_f;
            // Only the move instructions may touch register nibbles
            st_nxt.fm_en = (is_flt && xo10 == ifd_pkg::IFD_XO_MTFSF)
                           ? fmask_x : 32'h00000000; // RQ1
            st_nxt.cm_en = (is_ext && xo10 == ifd_pkg::IFD_XO_MTCRF)
                           ? cmask_x : 32'h00000000; // RQ2
            // Word offset: append 00 then sign-extend to address width
            st_nxt.bof = {{(ifd_pkg::IFD_AW - ifd_pkg::IFD_BOF_W - 2)
                           {ofs24[23]}}, ofs24, 2'h0}; // RQ3
            st_nxt.rmask = rmask; // RQ7 RQ8 RQ9
            // Return address is the word after this one
            st_nxt.lnk_en = lnk && (is_br || is_svc); // RQ4 RQ5
            st_nxt.lnk_val = INSTR_ADDR + 64'h0000000000000004;
            st_nxt.absf = dbit(INSTR_WORD, ifd_pkg::IFD_ABS_POS); // RQ22
            st_nxt.vix = 7'(dfield(INSTR_WORD, ifd_pkg::IFD_VIX_POS,
                                   ifd_pkg::IFD_VIX_W));
            // Vector form only when the absolute flag is clear
            st_nxt.vec = st_nxt.absf ? 13'h0000
                         : {1'h1, st_nxt.vix, 5'h00}; // RQ6 RQ22
            st_nxt.sf4 = 4'(dfield(INSTR_WORD, ifd_pkg::IFD_SF4_POS,
                                   ifd_pkg::IFD_NIB_W)); // RQ21
            st_nxt.sf3 = 3'(dfield(INSTR_WORD, ifd_pkg::IFD_SF3_POS,
                                   ifd_pkg::IFD_SF3_W)); // RQ21
            st_nxt.oe_en = is_ext &&
                           dbit(INSTR_WORD, ifd_pkg::IFD_OE_POS); // RQ12
            st_nxt.rec_fix = lnk && !is_flt && !is_br && !is_svc; // RQ13
            st_nxt.rec_flt = lnk && is_flt; // RQ14
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Reset presents a no-operation with every enable low
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            st_r <= '0; // RQ23
            st_r.opc <= ifd_pkg::IFD_NOP_WORD[31:26]; // RQ23
        end else begin
            st_r <= st_nxt; // RQ23
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign DEC_VALID = st_r.vld;
    assign PRIMARY_OPCODE = st_r.opc;
    assign FPR_TARGET = st_r.r610;
    assign FPR_STORE_SOURCE = st_r.r610;
    assign FPR_SOURCE_A = st_r.r1115;
    assign FPR_SOURCE_B = st_r.r1620;
    assign FPR_SOURCE_C = st_r.r2125;
    assign FIRST_GPR_OPERAND = st_r.r1115;
    assign SECOND_GPR_OPERAND = st_r.r1620;
    assign STRING_BYTE_COUNT = st_r.r1620;
    assign FLOAT_STATUS_IMM = st_r.imm4;
    assign EXT_OPCODE10 = st_r.xo10;
    assign EXT_OPCODE9 = st_r.xo9;
    assign FLOAT_STATUS_UPDATE_MASK = st_r.fmask;
    assign CONDITION_UPDATE_MASK = st_r.cmask;
    assign FLOAT_STATUS_WRITE_EN = st_r.fm_en;
    assign CONDITION_WRITE_EN = st_r.cm_en;
    assign LONG_BRANCH_OFFSET = st_r.bof;
    assign ROTATE_MASK = st_r.rmask;
    assign LINK_WRITE_EN = st_r.lnk_en;
    assign LINK_VALUE = st_r.lnk_val;
    assign SUPERVISOR_ABSOLUTE_FLAG = st_r.absf;
    assign SUPERVISOR_VECTOR_INDEX = st_r.vix;
    assign SUPERVISOR_VECTOR_ADDR = st_r.vec;
    assign SUPERVISOR_FOUR_BIT_FIELD = st_r.sf4;
    assign SUPERVISOR_THREE_BIT_FIELD = st_r.sf3;
    assign OVERFLOW_UPDATE_EN = st_r.oe_en;
    assign RECORD_FIXED_EN = st_r.rec_fix;
    assign RECORD_FLOAT_EN = st_r.rec_flt;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_opcode_field: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID |=> PRIMARY_OPCODE == $past(INSTR_WORD[31:26])) // RQ11
        else $error("primary opcode mismatch");
    a_branch_offset: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID |=> LONG_BRANCH_OFFSET[1:0] == 2'h0 &&
        LONG_BRANCH_OFFSET[63] == $past(INSTR_WORD[25])) // RQ3
        else $error("branch offset form wrong");
    a_link_branch: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID && INSTR_WORD[31:26] == 6'h12 |=>
        LINK_WRITE_EN == $past(INSTR_WORD[0])) // RQ4
        else $error("branch link enable wrong");
    a_link_svc: assert property (@(posedge REF_CLK) disable iff (SRST)
        LINK_WRITE_EN |-> LINK_VALUE == $past(INSTR_ADDR) + 64'h4) // RQ5
        else $error("link value not next address");
    a_vector_addr: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID && !INSTR_WORD[1] |=>
        SUPERVISOR_VECTOR_ADDR == {1'h1, $past(INSTR_WORD[11:5]),
        5'h00}) // RQ6
        else $error("vector address wrong");
    a_string_count: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID |=> STRING_BYTE_COUNT == $past(INSTR_WORD[15:11])) // RQ10
        else $error("byte count wrong");
    a_overflow_en: assert property (@(posedge REF_CLK) disable iff (SRST)
        OVERFLOW_UPDATE_EN |-> $past(INSTR_WORD[10])) // RQ12
        else $error("overflow enable without bit");
    a_record_fixed: assert property (@(posedge REF_CLK) disable iff (SRST)
        RECORD_FIXED_EN || RECORD_FLOAT_EN |-> $past(INSTR_WORD[0]) &&
        !(RECORD_FIXED_EN && RECORD_FLOAT_EN)) // RQ13
        else $error("record enable wrong");
    a_gpr_fields: assert property (@(posedge REF_CLK) disable iff (SRST)
        INSTR_VALID |=> FIRST_GPR_OPERAND == $past(INSTR_WORD[20:16]) &&
        FPR_TARGET == $past(INSTR_WORD[25:21])) // RQ19
        else $error("register specifier wrong");
    a_reset_quiet: assert property (@(posedge REF_CLK)
        $past(SRST) |-> !LINK_WRITE_EN && CONDITION_WRITE_EN == 32'h0) // RQ23
        else $error("enable active after reset");
    c_branch_link: cover property (@(posedge REF_CLK) LINK_WRITE_EN);
    c_mtcrf: cover property (@(posedge REF_CLK) CONDITION_WRITE_EN != 0);
    c_full_mask: cover property (@(posedge REF_CLK)
        ROTATE_MASK == 32'hffffffff);
    c_wrap_mask: cover property (@(posedge REF_CLK)
        ROTATE_MASK[31] && ROTATE_MASK[0] && ROTATE_MASK != 32'hffffffff);
endmodule

// file: verification/ifd_fetch_model.sv
// Fetch stage model: hands the decoder one instruction word a cycle.
// Assumes the decoder samples its inputs on the shared rising edge.
`timescale 1ns/10ps
module ifd_fetch_model (
    input wire logic clk,
    output logic valid,
    output logic [31:0] word,
    output logic [63:0] addr
);
    // Idle values from time zero
    initial begin
        valid = 1'b0;
        word = 32'h0;
        addr = 64'h0;
    end
    // Word launched just after an edge, held for the whole cycle
    task automatic send(input logic [31:0] w, input logic [63:0] a);
        @(posedge clk);
        #1;
        valid = 1'b1;
        word = w;
        addr = a;
    endtask
    // Stale word is inverted so the decoder cannot lean on it
    task automatic idle();
        @(posedge clk);
        #1;
        valid = 1'b0;
        word = ~word;
        addr = ~addr;
    endtask
endmodule

// file: verification/instruction_field_decoder_tb_top.sv
// Self-checking bench for the instruction field decoder.
// Assumes one-cycle registered outputs, qualified by DEC_VALID.
`timescale 1ns/10ps
module instruction_field_decoder_tb_top;
    // Expected decode of one word, grouped by output family
    typedef struct packed {
        logic [5:0] opc;
        logic [24:0] float_register;
        logic [14:0] general_register;
        logic [18:0] xo;
        logic [3:0] imm;
        logic [39:0] fsm;
        logic [39:0] cnm;
        logic [63:0] lbo;
        logic [31:0] rot;
        logic lwe;
        logic [63:0] lv;
        logic [20:0] svc;
        logic [6:0] sfl;
        logic [2:0] ctl;
    } ifd_tb_exp_s;
    logic ref_clk, srst, ivalid;
    logic [31:0] iword;
    logic [63:0] iaddr;
    logic dec_valid, lwe, saf, ove, rfx, rfl;
    logic [5:0] opc;
    logic [4:0] fpt, fps, fpa, fpb, fpc, ga, gb, nbc;
    logic [3:0] fim, sf4;
    logic [2:0] sf3;
    logic [9:0] x10;
    logic [8:0] x9;
    logic [7:0] fsm, cnm;
    logic [31:0] fwe, cwe, rot;
    logic [63:0] lbo, lv;
    logic [6:0] svi;
    logic [12:0] sva;
    ifd_tb_exp_s exp_q[$];
    ifd_tb_exp_s e;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 32'h13045392;
    logic [5:0] ops [6] = '{6'h12, 6'h11, 6'h1f, 6'h3f, 6'h3b, 6'h15};
    logic [9:0] xos [3] = '{10'h090, 10'h2c7, 10'h086};
    // Start and stop pairs on both sides of the wrap boundary
    logic [9:0] rot_p [9] = '{10'h01f, 10'h3e0, 10'h0a4, 10'h084, 10'h000,
                              10'h3ff, 10'h20f, 10'h283, 10'h001};
    logic [31:0] dir_w [10] = '{32'h4a000005, 32'h49fffff8, 32'h4400aff5,
        32'h4400aff6, 32'h7c0a5121, 32'h7c0a510c, 32'hfd02058f,
        32'hed02058f, 32'hfc00910c, 32'h7c000615};

    ifd_fetch_model ifd_fetch_model_i (.clk(ref_clk), .valid(ivalid),
        .word(iword), .addr(iaddr));
    ifd_decoder ifd_decoder_i (.REF_CLK(ref_clk), .SRST(srst),
        .INSTR_VALID(ivalid), .INSTR_WORD(iword), .INSTR_ADDR(iaddr),
        .DEC_VALID(dec_valid), .PRIMARY_OPCODE(opc), .FPR_TARGET(fpt),
        .FPR_STORE_SOURCE(fps), .FPR_SOURCE_A(fpa), .FPR_SOURCE_B(fpb),
        .FPR_SOURCE_C(fpc), .FIRST_GPR_OPERAND(ga), .SECOND_GPR_OPERAND(gb),
        .STRING_BYTE_COUNT(nbc), .FLOAT_STATUS_IMM(fim), .EXT_OPCODE10(x10),
        .EXT_OPCODE9(x9), .FLOAT_STATUS_UPDATE_MASK(fsm),
        .CONDITION_UPDATE_MASK(cnm), .FLOAT_STATUS_WRITE_EN(fwe),
        .CONDITION_WRITE_EN(cwe), .LONG_BRANCH_OFFSET(lbo),
        .ROTATE_MASK(rot), .LINK_WRITE_EN(lwe), .LINK_VALUE(lv),
        .SUPERVISOR_ABSOLUTE_FLAG(saf), .SUPERVISOR_VECTOR_INDEX(svi),
        .SUPERVISOR_VECTOR_ADDR(sva), .SUPERVISOR_FOUR_BIT_FIELD(sf4),
        .SUPERVISOR_THREE_BIT_FIELD(sf3), .OVERFLOW_UPDATE_EN(ove),
        .RECORD_FIXED_EN(rfx), .RECORD_FLOAT_EN(rfl));

    // ------------------------------------------------------------
    // Reference decode, worked out field by field from the word
    // ------------------------------------------------------------
    function automatic ifd_tb_exp_s predict(input logic [31:0] w,
                                            input logic [63:0] a);
        ifd_tb_exp_s r;
        logic [5:0] op;
        logic fl;
        logic bs;
        logic fen;
        logic cen;
        op = w[31:26];
        fl = (op == ifd_pkg::IFD_OP_FLT_A) || (op == ifd_pkg::IFD_OP_FLT_B);
        bs = (op == ifd_pkg::IFD_OP_BRANCH) || (op == ifd_pkg::IFD_OP_SVC);
        fen = fl && (w[10:1] == ifd_pkg::IFD_XO_MTFSF);
        cen = (op == ifd_pkg::IFD_OP_EXT) &&
              (w[10:1] == ifd_pkg::IFD_XO_MTCRF);
        r.opc = op;
        r.float_register = {w[25:21], w[25:21], w[20:16], w[15:11], w[10:6]};
        r.general_register = {w[20:16], w[15:11], w[15:11]};
        r.xo = {w[10:1], w[9:1]};
        r.imm = w[15:12];
        r.fsm[39:32] = w[24:17];
        r.cnm[39:32] = w[19:12];
        // Mask bit k of each field owns nibble k, first nibble on top
        for (int k = 0; k < 8; k++) begin
            r.fsm[31-4*k -: 4] = {4{w[24-k] & fen}};
            r.cnm[31-4*k -: 4] = {4{w[19-k] & cen}};
        end
        r.lbo = {{38{w[25]}}, w[25:2], 2'b00};
        // Wrapped range when start passes stop, full ones when adjacent
        for (int i = 0; i < 32; i++) begin
            r.rot[31-i] = (w[10:6] <= w[5:1]) ?
                (i >= w[10:6] && i <= w[5:1]) : !(i > w[5:1] && i < w[10:6]);
        end
        r.lwe = w[0] && bs;
        r.lv = a + 64'h4;
        r.svc = {w[1], w[11:5], w[1] ? 13'h0 : {1'b1, w[11:5], 5'h00}};
        r.sfl = {w[15:12], w[4:2]};
        r.ctl = {(op == ifd_pkg::IFD_OP_EXT) && w[10], w[0] && !fl && !bs,
                 w[0] && fl};
        return r;
    endfunction

    task automatic chk(input string nm, input logic [79:0] ev,
                       input logic [79:0] gv);
        samples_checked++;
        if (gv !== ev) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, ev, gv);
        end
    endtask

    // Note the expectation as the word is handed over
    task automatic drive(input logic [31:0] w, input logic [63:0] a);
        ifd_fetch_model_i.send(w, a);
        exp_q.push_back(predict(w, a));
    endtask

    // Without a word the decode must fall back to the no-op form
    task automatic check_idle();
        @(posedge ref_clk);
        #2;
        chk("idle decode", {1'b0, 6'h18, 1'b0, 64'h0, 3'h0},
            {dec_valid, opc, lwe, fwe, cwe, ove, rfx, rfl});
    endtask

    task automatic tally_and_finish();
        if (exp_q.size() != 0) begin
            fail_count++;
        end
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Watcher: every valid decode retires the oldest expectation
    always @(posedge ref_clk) begin
        #2;
        if (dec_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("wrong value dec_valid expected 0 seen 1");
            end else begin
                e = exp_q.pop_front();
                chk("opcode", e.opc, opc);
                chk("fpr", e.float_register, {fpt, fps, fpa, fpb, fpc});
                chk("gpr fields", e.general_register, {ga, gb, nbc});
                chk("ext opcodes", e.xo, {x10, x9});
                chk("status imm", e.imm, fim);
                chk("float mask", e.fsm, {fsm, fwe});
                chk("cond mask", e.cnm, {cnm, cwe});
                chk("branch offset", e.lbo, lbo);
                chk("rotate mask", e.rot, rot);
                chk("link", {e.lwe, e.lv}, {lwe, lv});
                chk("svc vector", e.svc, {saf, svi, sva});
                chk("svc fields", e.sfl, {sf4, sf3});
                chk("controls", e.ctl, {ove, rfx, rfl});
            end
        end
    end

    // Watchdog sized well past the few hundred cycles of the tests
    initial begin
        repeat (2000) @(posedge ref_clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] w;
        srst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        check_idle();
        $display("test reset done");
        // Directed words; first link address wraps past the top
        foreach (dir_w[j]) begin
            drive(dir_w[j], 64'hffff_ffff_ffff_fffc + 64'(4 * j));
        end
        $display("test directed done");
        foreach (rot_p[j]) begin
            w = $random(seed);
            w[31:26] = 6'h15;
            w[10:1] = rot_p[j];
            drive(w, 64'h1000);
        end
        $display("test rotate done");
        // Back-to-back random words over every opcode class
        for (int n = 0; n < 300; n++) begin
            w = $random(seed);
            w[31:26] = ops[$unsigned($random(seed)) % 6];
            if (w[11]) begin
                w[10:1] = xos[$unsigned($random(seed)) % 3];
            end
            drive(w, {$random(seed), $random(seed)});
        end
        $display("test random done");
        ifd_fetch_model_i.idle();
        check_idle();
        drive(32'h4a000005, 64'h40);
        ifd_fetch_model_i.idle();
        check_idle();
        $display("test idle done");
        repeat (2) @(posedge ref_clk);
        tally_and_finish();
    end
endmodule
